// ===== logic/aurts_top.v
// Asynchronous serial port: register file, baud timing, transmitter and receive buffer
`timescale 1ns/1ps
`include "aurts_consts.vh"

// Functional notes
// - Nine-bit transmit mode sends a ninth bit; one marks an address.
// - Setting transmit enable sets the transmit empty flag.
// - Transmit empty with all three enables raises the transmit interrupt one cycle later.
// - Writing the transmit data register starts sending that character.
// - Line sampled at sixteen times bit rate; shifter advances once per bit.
// - Finished characters move at once into a two-entry buffer.
// - Receiver runs only with continuous receive, asynchronous mode and port enabled.
// - Start edge checked at half a bit; if high, silently abandon.
// - Each later bit centre is a full bit on, majority voted, shifted in.
// - Stop position sampled one bit later; zero records a framing error.
// - At the stop bit centre the character is buffered; reading data pops the oldest.
// - While overrun is present no further characters are accepted.
// - Receive polarity bit one inverts the received line.
// - Receive-ready flag shows enabled receiver with unread data; software cannot write it.
// - Receive interrupt only when receive, peripheral and global enables and ready.
// - Each entry keeps its framing error; status shows the oldest, read-only.
// - Framing errors never stop reception; status follows reads, stays if all bad.
// - Port disable resets and clears framing status; receive disable does not.
// - Third character into a full buffer sets overrun; cleared by receive or port disable.
// - Least significant bit first, zero start bit, one stop bit, shared rate.
module aurts_top #(
	parameter DEPTH = 2
) (
	// Clock and reset
	input  wire       clk_sys,
	input  wire       reset_n,
	// Register port
	input  wire [2:0] reg_addr,
	input  wire [7:0] reg_wdata,
	input  wire       reg_wr,
	input  wire       reg_rd,
	output reg  [7:0] reg_rdata,
	// Serial lines
	input  wire       receive_line,
	output reg        transmit_line_out,
	output reg        transmit_line_oe,
	// Interrupt requests
	output reg        tx_irq,
	output reg        rx_irq
);

	reg        rst_meta;
	reg        rst_n;
	// Software-written control
	reg  [7:0] receive_status_control;
	reg  [7:0] transmit_status_control;
	reg  [7:0] baud_control;
	reg  [7:0] baud_divisor_high;
	reg  [7:0] baud_divisor_low;
	reg  [7:0] irq_control;
	// Baud timing
	reg  [15:0] baud_cnt;
	reg  [1:0]  pre_cnt;
	wire        baud_hit;
	wire        tick16;
	wire [15:0] divisor;
	// Transmit path
	reg  [8:0]  transmit_data_buffer;
	reg         tx_hold_full;
	reg  [10:0] tx_frame;
	reg  [3:0]  tx_bits_left;
	reg  [3:0]  tx_tcnt;
	reg         tx_busy;
	wire        tx_run;
	wire        tx_write;
	wire        transmit_empty_flag;
	// Receive path
	reg  [8:0]  fifo_data [0:DEPTH-1];
	reg         fifo_framing_error_status [0:DEPTH-1];
	reg         wr_ptr;
	reg         rd_ptr;
	reg  [1:0]  count;
	reg         overrun_error_status;
	wire        rx_enable;
	wire        rx_done;
	wire [8:0]  rx_data;
	wire        rx_framing_error_status;
	wire        rx_idle;
	wire        push;
	wire        pop;
	wire        receive_ready_flag;
	wire        framing_error_status;
	wire [8:0]  head_data;
	reg  [7:0]  next_rdata;

	wire port_enable               = receive_status_control[`AURTS_RC_PORT_ENABLE];
	wire continuous_receive_enable = receive_status_control[`AURTS_RC_CONT_RX];
	wire sync_mode                 = transmit_status_control[`AURTS_TC_SYNC_MODE];
	wire transmit_enable           = transmit_status_control[`AURTS_TC_ENABLE];
	wire nine_bit_transmit_select  = transmit_status_control[`AURTS_TC_NINE_BIT];
	wire transmit_ninth_bit        = transmit_status_control[`AURTS_TC_NINTH_BIT];
	wire high_speed_baud_select    = transmit_status_control[`AURTS_TC_HIGH_SPEED];
	wire wide_divisor_select       = baud_control[`AURTS_BC_WIDE_DIV];
	wire receive_polarity_invert   = baud_control[`AURTS_BC_RX_INVERT];
	wire transmit_polarity_invert  = baud_control[`AURTS_BC_TX_INVERT];

	// Reset release through two flops; assertion stays asynchronous
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// Register writes; status fields are derived, never stored from the bus
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			receive_status_control  <= `AURTS_RST_CTRL;
			transmit_status_control <= `AURTS_RST_CTRL;
			baud_control            <= `AURTS_RST_CTRL;
			baud_divisor_high       <= `AURTS_RST_DIV;
			baud_divisor_low        <= `AURTS_RST_DIV;
			irq_control             <= `AURTS_RST_CTRL;
		end else if (reg_wr) begin
			case (reg_addr)
				`AURTS_OFS_RX_CTRL: receive_status_control <= reg_wdata & 8'hf8;
				`AURTS_OFS_TX_CTRL: transmit_status_control <= reg_wdata & 8'hfd;
				`AURTS_OFS_BAUD_CTRL: baud_control <= reg_wdata & 8'h38;
				`AURTS_OFS_DIV_HIGH: baud_divisor_high <= reg_wdata;
				`AURTS_OFS_DIV_LOW: baud_divisor_low <= reg_wdata;
				`AURTS_OFS_IRQ_CTRL: irq_control <= reg_wdata & 8'hf0;
				default: ;
			endcase
		end
	end

	// Sixteen-times tick: divisor sets the rate, low speed adds a divide by four
	assign divisor  = wide_divisor_select ? {baud_divisor_high, baud_divisor_low}
		: {8'h00, baud_divisor_low};
	assign baud_hit = (baud_cnt == 16'h0000);
	assign tick16   = baud_hit && (high_speed_baud_select
		|| pre_cnt == `AURTS_LOW_SPEED_LAST);

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			baud_cnt <= 16'h0000;
			pre_cnt  <= 2'h0;
		end else if (!port_enable) begin
			baud_cnt <= 16'h0000;
			pre_cnt  <= 2'h0;
		end else if (baud_hit) begin
			baud_cnt <= divisor;
			pre_cnt  <= pre_cnt + 2'h1;
		end else begin
			baud_cnt <= baud_cnt - 16'h0001;
		end
	end

	// Transmitter runs only in asynchronous mode with port and transmit enabled
	assign tx_run              = transmit_enable && port_enable && !sync_mode;
	assign tx_write            = reg_wr && reg_addr == `AURTS_OFS_TX_DATA;
	assign transmit_empty_flag = transmit_enable && !tx_hold_full;

	// Holding buffer; the ninth bit is taken from control at the data write
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			transmit_data_buffer <= 9'h000;
			tx_hold_full         <= 1'b0;
		end else if (!port_enable) begin
			tx_hold_full <= 1'b0;
		end else if (tx_write) begin
			transmit_data_buffer <= {transmit_ninth_bit, reg_wdata};
			tx_hold_full         <= 1'b1;
		end else if (tx_run && !tx_busy) begin
			tx_hold_full <= 1'b0;
		end
	end

	// Shifter: start zero, data low bit first, optional ninth bit, stop one
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tx_frame     <= 11'h7ff;
			tx_bits_left <= 4'h0;
			tx_tcnt      <= 4'h0;
			tx_busy      <= 1'b0;
		end else if (!tx_run) begin
			tx_busy  <= 1'b0;
			tx_frame <= 11'h7ff;
		end else if (!tx_busy) begin
			if (tx_hold_full) begin
				tx_busy      <= 1'b1;
				tx_tcnt      <= 4'h0;
				tx_frame     <= nine_bit_transmit_select
					? {1'b1, transmit_data_buffer, 1'b0}
					: {2'b11, transmit_data_buffer[7:0], 1'b0};
				tx_bits_left <= nine_bit_transmit_select ? 4'ha : 4'h9;
			end
		end else if (tick16) begin
			tx_tcnt <= tx_tcnt + 4'h1;
			if (tx_tcnt == `AURTS_TICK_LAST) begin
				tx_frame     <= {1'b1, tx_frame[10:1]};
				tx_bits_left <= tx_bits_left - 4'h1;
				if (tx_bits_left == 4'h0) begin
					tx_busy <= 1'b0;
				end
			end
		end
	end

	// Line drive; idle is mark, inverted on request
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			transmit_line_out <= 1'b1;
			transmit_line_oe  <= 1'b0;
		end else begin
			transmit_line_out <= (tx_busy ? tx_frame[0] : 1'b1) ^ transmit_polarity_invert;
			transmit_line_oe  <= port_enable;
		end
	end

	// Receiver only in asynchronous mode with both enables set
	assign rx_enable = continuous_receive_enable && !sync_mode && port_enable;

	aurts_rx_recovery u_recovery (
		.clk_sys   (clk_sys),
		.rst_n     (rst_n),
		.enable    (rx_enable),
		.tick16    (tick16),
		.nine_bit  (receive_status_control[`AURTS_RC_NINE_BIT]),
		.line_in   (receive_line ^ receive_polarity_invert),
		.done      (rx_done),
		.done_data (rx_data),
		.done_framing_error_status (rx_framing_error_status),
		.idle      (rx_idle)
	);

	// Buffer control; overrun blocks pushes until cleared
	assign push = rx_done && (count != DEPTH[1:0] || pop) && !overrun_error_status;
	assign pop  = reg_rd && reg_addr == `AURTS_OFS_RX_DATA && count != 2'h0;
	assign head_data            = fifo_data[rd_ptr];
	assign framing_error_status = (count != 2'h0) && fifo_framing_error_status[rd_ptr];
	assign receive_ready_flag   = rx_enable && count != 2'h0;

	// Entries carry their own framing bit, so status moves with each read
	genvar gi;
	generate
		for (gi = 0; gi < DEPTH; gi = gi + 1) begin : g_entry
			always @(posedge clk_sys or negedge rst_n) begin
				if (!rst_n) begin
					fifo_data[gi] <= 9'h000;
					fifo_framing_error_status[gi] <= 1'b0;
				end else if (push && wr_ptr == gi) begin
					fifo_data[gi] <= rx_data;
					fifo_framing_error_status[gi] <= rx_framing_error_status;
				end
			end
		end
	endgenerate

	// Pointers and fill level; port disable empties the buffer
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			count  <= 2'h0;
		end else if (!port_enable) begin
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			count  <= 2'h0;
		end else begin
			if (push) wr_ptr <= !wr_ptr;
			if (pop) rd_ptr <= !rd_ptr;
			if (push && !pop) count <= count + 2'h1;
			else if (pop && !push) count <= count - 2'h1;
		end
	end

	// Overrun: a complete character meeting a full buffer; set wins over clear
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			overrun_error_status <= 1'b0;
		end else if (rx_done && count == DEPTH[1:0] && !pop && rx_enable) begin
			overrun_error_status <= 1'b1;
		end else if (!continuous_receive_enable || !port_enable) begin
			overrun_error_status <= 1'b0;
		end
	end

	// Requests follow flags and enables; framing errors alone raise nothing
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tx_irq <= 1'b0;
			rx_irq <= 1'b0;
		end else begin
			tx_irq <= transmit_empty_flag && irq_control[`AURTS_IC_TX_EN]
				&& irq_control[`AURTS_IC_PERIPH_EN] && irq_control[`AURTS_IC_GLOBAL_EN];
			rx_irq <= receive_ready_flag && irq_control[`AURTS_IC_RX_EN]
				&& irq_control[`AURTS_IC_PERIPH_EN]
				&& irq_control[`AURTS_IC_GLOBAL_EN];
		end
	end

	// Read mux; data register returns the oldest character, unmapped reads zero
	always @* begin
		next_rdata = 8'h00;
		case (reg_addr)
			`AURTS_OFS_RX_CTRL: begin
				next_rdata = receive_status_control;
				next_rdata[`AURTS_RC_FRAME_ERR] = framing_error_status;
				next_rdata[`AURTS_RC_OVERRUN]   = overrun_error_status;
				next_rdata[`AURTS_RC_NINTH_BIT] = (count != 2'h0) && head_data[8];
			end
			`AURTS_OFS_TX_CTRL: begin
				next_rdata = transmit_status_control;
				next_rdata[`AURTS_TC_SHIFTER_EMPTY] = !tx_busy;
			end
			`AURTS_OFS_BAUD_CTRL: begin
				next_rdata = baud_control;
				next_rdata[`AURTS_BC_RX_IDLE] = rx_idle;
			end
			`AURTS_OFS_DIV_HIGH: next_rdata = baud_divisor_high;
			`AURTS_OFS_DIV_LOW: next_rdata = baud_divisor_low;
			`AURTS_OFS_RX_DATA: next_rdata = (count != 2'h0) ? head_data[7:0] : 8'h00;
			`AURTS_OFS_IRQ_CTRL: begin
				next_rdata = irq_control;
				next_rdata[`AURTS_IC_RX_READY] = receive_ready_flag;
				next_rdata[`AURTS_IC_TX_EMPTY] = transmit_empty_flag;
			end
			default: next_rdata = 8'h00;
		endcase
	end

	// Read data stands for the single cycle after the strobe
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= next_rdata;
		end else begin
			reg_rdata <= 8'h00;
		end
	end

endmodule

// ===== logic/aurts_consts.vh
// Register map, field positions, reset values and timing counts of the serial port
`ifndef AURTS_CONSTS_VH
`define AURTS_CONSTS_VH

// Register offsets on the plain register port
`define AURTS_ADDR_W            3
`define AURTS_OFS_RX_CTRL       3'h0
`define AURTS_OFS_TX_DATA       3'h1
`define AURTS_OFS_TX_CTRL       3'h2
`define AURTS_OFS_BAUD_CTRL     3'h3
`define AURTS_OFS_DIV_HIGH      3'h4
`define AURTS_OFS_DIV_LOW       3'h5
`define AURTS_OFS_RX_DATA       3'h6
`define AURTS_OFS_IRQ_CTRL      3'h7

// Receive status and control fields
`define AURTS_RC_PORT_ENABLE    7
`define AURTS_RC_NINE_BIT       6
`define AURTS_RC_SINGLE_RX      5
`define AURTS_RC_CONT_RX        4
`define AURTS_RC_ADDR_DETECT    3
`define AURTS_RC_FRAME_ERR      2
`define AURTS_RC_OVERRUN        1
`define AURTS_RC_NINTH_BIT      0

// Transmit status and control fields
`define AURTS_TC_CLOCK_SRC      7
`define AURTS_TC_NINE_BIT       6
`define AURTS_TC_ENABLE         5
`define AURTS_TC_SYNC_MODE      4
`define AURTS_TC_SEND_BREAK     3
`define AURTS_TC_HIGH_SPEED     2
`define AURTS_TC_SHIFTER_EMPTY  1
`define AURTS_TC_NINTH_BIT      0

// Baud control fields
`define AURTS_BC_RX_IDLE        6
`define AURTS_BC_RX_INVERT      5
`define AURTS_BC_TX_INVERT      4
`define AURTS_BC_WIDE_DIV       3

// Interrupt enable and flag fields
`define AURTS_IC_GLOBAL_EN      7
`define AURTS_IC_PERIPH_EN      6
`define AURTS_IC_RX_EN          5
`define AURTS_IC_TX_EN          4
`define AURTS_IC_RX_READY       1
`define AURTS_IC_TX_EMPTY       0

// Reset values
`define AURTS_RST_CTRL          8'h00
`define AURTS_RST_DIV           8'h00

// Oversampling: ticks per bit run 0..15, votes taken at 7, 8 and 9
`define AURTS_TICK_LAST         4'hf
`define AURTS_VOTE_A            4'h7
`define AURTS_VOTE_B            4'h8
`define AURTS_VOTE_C            4'h9
`define AURTS_LOW_SPEED_LAST    2'h3

`endif

// ===== logic/aurts_rx_recovery.v
// Receive data recovery: start check, majority voting and character assembly
`timescale 1ns/1ps
`include "aurts_consts.vh"

module aurts_rx_recovery (
	// Clock and reset
	input  wire       clk_sys,
	input  wire       rst_n,
	// Control
	input  wire       enable,
	input  wire       tick16,
	input  wire       nine_bit,
	input  wire       line_in,
	// Finished character
	output reg        done,
	output reg  [8:0] done_data,
	output reg        done_framing_error_status,
	output wire       idle
);

	localparam S_IDLE  = 4'b0001;
	localparam S_START = 4'b0010;
	localparam S_DATA  = 4'b0100;
	localparam S_STOP  = 4'b1000;

	reg  [3:0] state;
	reg  [3:0] tcnt;
	reg  [3:0] nbits;
	reg  [8:0] receive_shifter;
	reg        line_q;
	reg        vote_a;
	reg        vote_b;
	wire       vote;
	wire [3:0] last_bit;

	// Two of three samples around the bit centre decide the bit
	assign vote     = (vote_a & vote_b) | (vote_a & line_in) | (vote_b & line_in);
	assign last_bit = nine_bit ? 4'h9 : 4'h8;
	assign idle     = (state == S_IDLE);

	// Previous oversample of the line, for falling edge detection
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			line_q <= 1'b1;
		end else if (tick16) begin
			line_q <= line_in;
		end
	end

	// Bit timing and shifting, all paced by the sixteen-times tick
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state           <= S_IDLE;
			tcnt            <= 4'h0;
			nbits           <= 4'h0;
			receive_shifter <= 9'h000;
			vote_a          <= 1'b1;
			vote_b          <= 1'b1;
			done            <= 1'b0;
			done_data       <= 9'h000;
			done_framing_error_status       <= 1'b0;
		end else begin
			done <= 1'b0;
			if (!enable) begin
				state <= S_IDLE;
				tcnt  <= 4'h0;
			end else if (tick16) begin
				tcnt <= tcnt + 4'h1;
				if (tcnt == `AURTS_VOTE_A) vote_a <= line_in;
				if (tcnt == `AURTS_VOTE_B) vote_b <= line_in;
				case (state)
					S_IDLE: begin
						tcnt <= 4'h1;
						if (line_q && !line_in) begin
							state <= S_START;
						end
					end
					S_START: begin
						// A start that is high at its centre was a glitch
						if (tcnt == `AURTS_VOTE_C && vote) begin
							state <= S_IDLE;
						end else if (tcnt == `AURTS_TICK_LAST) begin
							state <= S_DATA;
							nbits <= 4'h0;
						end
					end
					S_DATA: begin
						// Least significant bit arrives first, so shift right
						if (tcnt == `AURTS_VOTE_C) begin
							receive_shifter <= {vote, receive_shifter[8:1]};
							nbits           <= nbits + 4'h1;
						end else if (tcnt == `AURTS_TICK_LAST && nbits == last_bit) begin
							state <= S_STOP;
						end
					end
					S_STOP: begin
						// Handed over at the stop centre, not at its end
						if (tcnt == `AURTS_VOTE_C) begin
							done      <= 1'b1;
							done_framing_error_status <= !vote;
							done_data <= nine_bit ? receive_shifter
								: {1'b0, receive_shifter[8:1]};
							state     <= S_IDLE;
						end
					end
					default: begin
						state <= S_IDLE;
					end
				endcase
			end
		end
	end

endmodule

// ===== bench/aurts_checker.sv
// Concurrent checks on the serial port's register answers, interrupts and line
`timescale 1ns/1ps
`include "aurts_consts.vh"

module aurts_checker #(
	parameter DEPTH = 2
) (
	input wire       clk_sys,
	input wire       reset_n,
	input wire [2:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire       reg_wr,
	input wire       reg_rd,
	input wire [7:0] reg_rdata,
	input wire       receive_line,
	input wire       transmit_line_out,
	input wire       transmit_line_oe,
	input wire       tx_irq,
	input wire       rx_irq
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	// Control writes; the irq outputs lag the enables by one register stage
	sequence rx_ctrl_wr;
		reg_wr && reg_addr == `AURTS_OFS_RX_CTRL;
	endsequence
	sequence irq_wr;
		reg_wr && reg_addr == `AURTS_OFS_IRQ_CTRL;
	endsequence

	rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data not zero outside a read answer");
	wo_read_zero_a: assert property (reg_rd && reg_addr == `AURTS_OFS_TX_DATA
		|=> reg_rdata == 8'h00)
		else $error("transmit data register readable");
	baud_reserved_a: assert property (reg_rd && reg_addr == `AURTS_OFS_BAUD_CTRL
		|=> reg_rdata[2:0] == 3'h0 && !reg_rdata[7])
		else $error("reserved baud control bits not zero");
	irq_gate_a: assert property (irq_wr ##0 !(reg_wdata[7] && reg_wdata[6])
		##1 !reg_wr |=> !tx_irq && !rx_irq)
		else $error("interrupt raised without global and peripheral enable");
	rx_gate_a: assert property (irq_wr ##0 !reg_wdata[`AURTS_IC_RX_EN] ##1 !reg_wr
		|=> !rx_irq)
		else $error("receive interrupt raised while disabled");
	tx_gate_a: assert property (irq_wr ##0 !reg_wdata[`AURTS_IC_TX_EN] ##1 !reg_wr
		|=> !tx_irq)
		else $error("transmit interrupt raised while disabled");
	port_off_a: assert property (rx_ctrl_wr ##0 !reg_wdata[7] ##1 !reg_wr
		|=> ##1 !rx_irq && !transmit_line_oe)
		else $error("port disable left receiver or line active");
	oe_on_a: assert property (rx_ctrl_wr ##0 reg_wdata[7] ##1 !reg_wr |=> transmit_line_oe)
		else $error("port enable did not drive the line");
	// Each bit lasts sixteen ticks, at least sixteen clocks at the fastest rate
	low_hold_a: assert property ($fell(transmit_line_out) && transmit_line_oe
		|=> (!transmit_line_out || !transmit_line_oe) [*8])
		else $error("low line level shorter than a bit");
	high_hold_a: assert property ($rose(transmit_line_out) && transmit_line_oe
		|=> (transmit_line_out || !transmit_line_oe) [*8])
		else $error("high line level shorter than a bit");
endmodule

bind aurts_top aurts_checker #(.DEPTH(DEPTH)) u_checker (
	.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .receive_line(receive_line),
	.transmit_line_out(transmit_line_out), .transmit_line_oe(transmit_line_oe),
	.tx_irq(tx_irq), .rx_irq(rx_irq));

// ===== bench/aurts_remote_node.sv
// Remote serial node: sends characters to the port and captures what it sends
`timescale 1ns/1ps

module aurts_remote_node (
	// Clock
	input  wire clk_sys,
	// Lines
	input  wire line_inv,
	input  wire transmit_line_out,
	output wire receive_line
);
	localparam integer BIT_CLKS = 16;
	reg drive = 1'b1;

	// Mark idle; low-true levels when the port is set to invert
	// Continuous drive so the line is defined from time zero, not only after a change
	assign receive_line = drive ^ line_inv;

	task bit_out(input b);
		begin
			drive <= b;
			repeat (BIT_CLKS) @(posedge clk_sys);
		end
	endtask
	// Zero start, data lsb first, stop as asked, then one idle bit
	task send(input [8:0] d, input integer nb, input stop_ok);
		integer i;
		begin
			bit_out(1'b0);
			for (i = 0; i < nb; i = i + 1)
				bit_out(d[i]);
			bit_out(stop_ok);
			bit_out(1'b1);
		end
	endtask
	// Short low pulse, well under half a bit
	task glitch(input integer n);
		begin
			drive <= 1'b0;
			repeat (n) @(posedge clk_sys);
			bit_out(1'b1);
		end
	endtask
	// Bit centres after the falling edge; the stop level lands above the data
	task capture(output [9:0] d, input integer nb);
		integer i, n;
		begin
			d = 10'h000;
			n = 0;
			while (transmit_line_out === 1'b1 && n < 4000) begin
				@(posedge clk_sys);
				n = n + 1;
			end
			repeat (BIT_CLKS / 2) @(posedge clk_sys);
			for (i = 0; i <= nb; i = i + 1) begin
				repeat (BIT_CLKS) @(posedge clk_sys);
				d[i] = transmit_line_out;
			end
		end
	endtask
endmodule

// ===== bench/tb_top.sv
// Self-checking bench for the asynchronous serial port
`timescale 1ns/1ps
`include "aurts_consts.vh"

module tb_top;
	localparam [2:0] rxc = `AURTS_OFS_RX_CTRL;
	localparam [2:0] txd = `AURTS_OFS_TX_DATA;
	localparam [2:0] txc = `AURTS_OFS_TX_CTRL;
	localparam [2:0] bdc = `AURTS_OFS_BAUD_CTRL;
	localparam [2:0] rxd = `AURTS_OFS_RX_DATA;
	localparam [2:0] irc = `AURTS_OFS_IRQ_CTRL;
	reg        clk_sys   = 1'b0;
	reg        reset_n   = 1'b0;
	reg  [2:0] reg_addr  = 3'h0;
	reg  [7:0] reg_wdata = 8'h00;
	reg        reg_wr    = 1'b0;
	reg        reg_rd    = 1'b0;
	reg        line_inv  = 1'b0;
	wire [7:0] reg_rdata;
	wire       receive_line;
	wire       transmit_line_out;
	wire       transmit_line_oe;
	wire       tx_irq;
	wire       rx_irq;
	integer    fail_count = 0;
	integer    compares   = 0;
	integer    cycles     = 0;
	integer    a;
	reg  [7:0] rv;
	reg  [9:0] cap;

	// 250 MHz system clock
	always #2 clk_sys = ~clk_sys;

	aurts_top #(.DEPTH(2)) uut (.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.receive_line(receive_line), .transmit_line_out(transmit_line_out),
		.transmit_line_oe(transmit_line_oe), .tx_irq(tx_irq), .rx_irq(rx_irq));
	aurts_remote_node remote (.clk_sys(clk_sys), .line_inv(line_inv),
		.transmit_line_out(transmit_line_out), .receive_line(receive_line));

	task tally_and_finish;
		begin
			$display("compares %0d fail_count %0d", compares, fail_count);
			if (fail_count == 0 && compares > 0)
				$display("[ PASS ]");
			else
				$display("[ FAIL ]");
			$finish;
		end
	endtask
	task check(input [79:0] what, input [9:0] seen, input [9:0] exp);
		begin
			compares = compares + 1;
			if (seen !== exp) begin
				fail_count = fail_count + 1;
				$display("unexpected %0s: expected %h seen %h", what, exp, seen);
			end
		end
	endtask
	// One-cycle strobes; the spare cycle keeps strobes from being set twice in a step
	task wr(input [2:0] ad, input [7:0] d);
		begin
			reg_addr <= ad;
			reg_wdata <= d;
			reg_wr <= 1'b1;
			@(posedge clk_sys);
			reg_wr <= 1'b0;
			@(posedge clk_sys);
		end
	endtask
	task rdchk(input [79:0] what, input [2:0] ad, input [7:0] mask, input [7:0] exp);
		begin
			reg_addr <= ad;
			reg_rd <= 1'b1;
			@(posedge clk_sys);
			reg_rd <= 1'b0;
			#1 rv = reg_rdata;
			check(what, {2'b00, rv & mask}, {2'b00, exp});
			@(posedge clk_sys);
		end
	endtask
	task idle(input integer n);
		repeat (n) @(posedge clk_sys);
	endtask

	task t_reset;
		begin
			for (a = 0; a < 8; a = a + 1)
				rdchk("reset", a[2:0], 8'hff, (a == 2) ? 8'h02 : ((a == 3) ? 8'h40 : 8'h00));
			check("oe reset", {9'h000, transmit_line_oe}, 10'h000);
		end
	endtask
	task t_tx;
		begin
			wr(`AURTS_OFS_DIV_LOW, 8'h00);
			wr(txc, 8'h24);
			wr(rxc, 8'h80);
			rdchk("tx empty", irc, 8'h01, 8'h01);
			wr(irc, 8'hd0);
			idle(1);
			check("tx irq", {9'h000, tx_irq}, 10'h001);
			fork
				remote.capture(cap, 8);
				wr(txd, 8'ha5);
			join
			check("tx frame", cap, 10'h1a5);
			idle(16);
			wr(txc, 8'h65);
			fork
				remote.capture(cap, 9);
				wr(txd, 8'h3c);
			join
			check("tx nine", cap, 10'h33c);
			idle(16);
		end
	endtask
	task t_rx;
		begin
			wr(rxc, 8'h90);
			remote.send(9'h05a, 8, 1'b1);
			remote.send(9'h0c3, 8, 1'b0);
			wr(irc, 8'ha0);
			idle(1);
			check("rx irq off", {9'h000, rx_irq}, 10'h000);
			wr(irc, 8'he0);
			idle(1);
			check("rx irq", {9'h000, rx_irq}, 10'h001);
			rdchk("rx ready", irc, 8'h02, 8'h02);
			rdchk("framing_error_status 1", rxc, 8'hff, 8'h90);
			rdchk("rx data 1", rxd, 8'hff, 8'h5a);
			rdchk("framing_error_status 2", rxc, 8'hff, 8'h94);
			rdchk("rx data 2", rxd, 8'hff, 8'hc3);
			wr(irc, 8'h02);
			rdchk("rx empty", irc, 8'h02, 8'h00);
		end
	endtask
	task t_false;
		begin
			remote.glitch(4);
			idle(64);
			rdchk("no start", irc, 8'h02, 8'h00);
			rdchk("no error", rxc, 8'hff, 8'h90);
		end
	endtask
	task t_overrun;
		begin
			remote.send(9'h011, 8, 1'b0);
			remote.send(9'h022, 8, 1'b0);
			remote.send(9'h033, 8, 1'b1);
			remote.send(9'h044, 8, 1'b1);
			rdchk("overrun", rxc, 8'hff, 8'h96);
			rdchk("keep 1", rxd, 8'hff, 8'h11);
			rdchk("framing_error_status kept", rxc, 8'h04, 8'h04);
			rdchk("keep 2", rxd, 8'hff, 8'h22);
			rdchk("no third", irc, 8'h02, 8'h00);
			wr(rxc, 8'h80);
			rdchk("ovr clear", rxc, 8'hff, 8'h80);
		end
	endtask
	task t_framing_error_status_clear;
		begin
			wr(rxc, 8'h90);
			remote.send(9'h055, 8, 1'b0);
			wr(rxc, 8'h80);
			rdchk("continuous_receive_enable framing_error_status", rxc, 8'hff, 8'h84);
			wr(rxc, 8'h00);
			rdchk("port framing_error_status", rxc, 8'hff, 8'h00);
			check("oe off", {9'h000, transmit_line_oe}, 10'h000);
		end
	endtask
	task t_invert;
		begin
			line_inv <= 1'b1;
			wr(bdc, 8'ha7);
			rdchk("bdc ro", bdc, 8'hbf, 8'h20);
			wr(rxc, 8'hd0);
			remote.send(9'h1a7, 9, 1'b1);
			rdchk("inv framing_error_status", rxc, 8'h05, 8'h01);
			rdchk("inverted", rxd, 8'hff, 8'ha7);
		end
	endtask

	// Hang guard, well above the few thousand cycles the tests need
	always @(posedge clk_sys) begin
		cycles = cycles + 1;
		if (cycles == 30000) begin
			fail_count = fail_count + 1;
			tally_and_finish;
		end
	end

	initial begin
		repeat (8) @(posedge clk_sys);
		reset_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		t_reset;
		t_tx;
		t_rx;
		t_false;
		t_overrun;
		t_framing_error_status_clear;
		t_invert;
		tally_and_finish;
	end
endmodule
